// >>> core/alarm_output.v
`timescale 1ns/1ps
`default_nettype none
module alarm_output (
	input wire clk_sys_i,
	input wire reset_n_i,
	input wire sample_valid_i,
	input wire event_i,
	input wire ended_i,
	input wire [1:0] queue_code_i,
	input wire comparator_i,
	input wire active_high_i,
	input wire clear_i,
	output reg alarm_o
);
	reg [2:0] count_reg;
	reg active_reg;
	reg [2:0] count_next;
	reg active_next;
	reg [2:0] need;

	always @* begin
		case (queue_code_i)
			2'h0: need = 3'h1;
			2'h1: need = 3'h2;
			2'h2: need = 3'h3;
			default: need = 3'h4;
		endcase
		count_next = count_reg;
		active_next = active_reg;
		if (clear_i && !comparator_i)
			active_next = 1'b0;
		if (sample_valid_i) begin
			if (event_i) begin
				if (count_reg < need)
					count_next = count_reg + 3'h1;
				if (count_reg + 3'h1 >= need)
					active_next = 1'b1;
			end else begin
				count_next = 3'h0;
				if (comparator_i && ended_i)
					active_next = 1'b0;
			end
		end
	end

	always @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			count_reg <= 3'h0;
			active_reg <= 1'b0;
			alarm_o <= 1'b1;
		end else begin
			count_reg <= count_next;
			active_reg <= active_next;
			alarm_o <= active_next ~^ active_high_i;
		end
	end
endmodule // alarm_output
`default_nettype wire

// >>> core/temp_sensor_regs.v
`timescale 1ns/1ps
`default_nettype none
`include "temp_sensor_defs.vh"
module temp_sensor_regs #(
	parameter [4:0] MAKER_ID = 5'h0A, // arbitrary value
	parameter [2:0] REVISION_ID = 3'h1, // arbitrary value
	parameter [31:0] CONT_CYCLES = `CONT_CONV_MS * `CYC_PER_MS,
	parameter [31:0] ONESHOT_CYCLES = `ONESHOT_CONV_MS * `CYC_PER_MS,
	parameter [31:0] SPS_CONV_CYCLES = `SPS_CONV_MS * `CYC_PER_MS,
	parameter [31:0] SPS_PERIOD_CYCLES = `SPS_PERIOD_MS * `CYC_PER_MS
) (
	input wire clk_sys_i,
	input wire reset_n_i,
	input wire sclk_i,
	input wire cs_n_i,
	input wire mosi_i,
	output reg miso_o,
	output reg miso_oe_o,
	input wire [15:0] adc_sample_i,
	input wire [15:0] critical_limit_i,
	input wire [15:0] high_limit_i,
	input wire [15:0] low_limit_i,
	input wire [3:0] limit_hysteresis_i,
	output wire critical_alarm_out_o,
	output wire limit_alarm_out_o,
	output reg converting_o
);
	localparam [2:0] ST_IDLE = 3'b001;
	localparam [2:0] ST_CONV = 3'b010;
	localparam [2:0] ST_GAP = 3'b100;

	reg sclk_meta_reg, sclk_sync_reg, sclk_prev_reg;
	reg cs_meta_reg, cs_sync_reg;
	reg mosi_meta_reg, mosi_sync_reg;
	reg [4:0] bit_cnt_reg;
	reg [6:0] rx_reg;
	reg [7:0] cmd_reg;
	reg [15:0] tx_reg;
	reg [7:0] sensor_settings_reg;
	reg [15:0] measured_temperature_reg;
	reg settings_wr_reg;
	reg temp_read_reg;
	reg [2:0] state_reg, state_next;
	reg [31:0] timer_reg, timer_next;
	reg done_reg;
	reg done_next;

	wire sclk_rise = sclk_sync_reg & ~sclk_prev_reg;
	wire sclk_fall = ~sclk_sync_reg & sclk_prev_reg;
	wire cs_active = ~cs_sync_reg;
	wire [7:0] cmd_now = {rx_reg, mosi_sync_reg};
	wire [1:0] mode = sensor_settings_reg[`SET_MODE_MSB:`SET_MODE_LSB];
	wire res16 = sensor_settings_reg[`SET_RES16];
	wire [7:0] maker_and_revision = {MAKER_ID, REVISION_ID};

	// Two-flop synchronisers for the serial pins
	always @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			sclk_meta_reg <= 1'b1;
			sclk_sync_reg <= 1'b1;
			sclk_prev_reg <= 1'b1;
			cs_meta_reg <= 1'b1;
			cs_sync_reg <= 1'b1;
			mosi_meta_reg <= 1'b0;
			mosi_sync_reg <= 1'b0;
		end else begin
			sclk_meta_reg <= sclk_i;
			sclk_sync_reg <= sclk_meta_reg;
			sclk_prev_reg <= sclk_sync_reg;
			cs_meta_reg <= cs_n_i;
			cs_sync_reg <= cs_meta_reg;
			mosi_meta_reg <= mosi_i;
			mosi_sync_reg <= mosi_meta_reg;
		end
	end

	// Read data, left aligned for MSB-first shifting
	function [15:0] read_word;
		input [2:0] addr;
		begin
			case (addr)
				`ADDR_SENSOR_SETTINGS:
					read_word = {sensor_settings_reg, 8'h00};
				`ADDR_MEASURED_TEMP:
					read_word = measured_temperature_reg;
				`ADDR_MAKER_REV:
					read_word = {maker_and_revision, 8'h00};
				default:
					read_word = 16'h0000;
			endcase
		end
	endfunction

	// Serial frame: command byte, then data bytes, mode 3 timing
	always @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			bit_cnt_reg <= 5'h00;
			rx_reg <= 7'h00;
			cmd_reg <= 8'h00;
			tx_reg <= 16'h0000;
			miso_o <= 1'b0;
			miso_oe_o <= 1'b0;
			sensor_settings_reg <= `SET_RESET;
			settings_wr_reg <= 1'b0;
			temp_read_reg <= 1'b0;
		end else begin
			settings_wr_reg <= 1'b0;
			temp_read_reg <= 1'b0;
			miso_oe_o <= cs_active;
			if (!cs_active) begin
				bit_cnt_reg <= 5'h00;
				cmd_reg <= 8'h00;
				miso_o <= 1'b0;
			end else begin
				if (sclk_rise) begin
					rx_reg <= cmd_now[6:0];
					if (bit_cnt_reg != 5'h1F)
						bit_cnt_reg <= bit_cnt_reg + 5'h01;
					if (bit_cnt_reg == 5'h07) begin
						cmd_reg <= cmd_now;
						tx_reg <= read_word(
							cmd_now[`CMD_ADDR_MSB:`CMD_ADDR_LSB]);
						if (cmd_now[`CMD_READ_BIT] &&
						    cmd_now[`CMD_ADDR_MSB:`CMD_ADDR_LSB] ==
						    `ADDR_MEASURED_TEMP)
							temp_read_reg <= 1'b1;
					end
					if (bit_cnt_reg == 5'h0F &&
					    !cmd_reg[`CMD_READ_BIT] &&
					    cmd_reg[`CMD_ADDR_MSB:`CMD_ADDR_LSB] ==
					    `ADDR_SENSOR_SETTINGS) begin
						sensor_settings_reg <= cmd_now;
						settings_wr_reg <= 1'b1;
					end
				end
				if (sclk_fall && bit_cnt_reg >= 5'h08 &&
				    cmd_reg[`CMD_READ_BIT]) begin
					miso_o <= tx_reg[15];
					tx_reg <= {tx_reg[14:0], 1'b0};
				end
			end
		end
	end

	// Conversion sequencer
	always @* begin
		state_next = state_reg;
		timer_next = timer_reg;
		done_next = 1'b0;
		case (state_reg)
			ST_IDLE: begin
				if (mode == `MODE_CONT) begin
					state_next = ST_CONV;
					timer_next = CONT_CYCLES;
				end else if (settings_wr_reg &&
				             mode == `MODE_ONESHOT) begin
					state_next = ST_CONV;
					timer_next = ONESHOT_CYCLES;
				end else if (settings_wr_reg &&
				             mode == `MODE_SPS) begin
					state_next = ST_CONV;
					timer_next = SPS_CONV_CYCLES;
				end
			end
			ST_CONV: begin
				if (settings_wr_reg) begin
					state_next = (mode == `MODE_SHUTDOWN) ?
						ST_IDLE : ST_CONV;
					case (mode)
						`MODE_CONT: timer_next = CONT_CYCLES;
						`MODE_ONESHOT: timer_next = ONESHOT_CYCLES;
						`MODE_SPS: timer_next = SPS_CONV_CYCLES;
						default: timer_next = 32'h00000000;
					endcase
				end else if (timer_reg <= 32'h00000001) begin
					done_next = 1'b1;
					case (mode)
						`MODE_CONT: timer_next = CONT_CYCLES;
						// Idle out the rest of the second
						`MODE_SPS: begin
							state_next = ST_GAP;
							timer_next = SPS_PERIOD_CYCLES -
								SPS_CONV_CYCLES;
						end
						default: state_next = ST_IDLE;
					endcase
				end else begin
					timer_next = timer_reg - 32'h00000001;
				end
			end
			ST_GAP: begin
				if (settings_wr_reg) begin
					state_next = ST_IDLE;
					timer_next = 32'h00000000;
				end else if (timer_reg <= 32'h00000001) begin
					state_next = ST_CONV;
					timer_next = SPS_CONV_CYCLES;
				end else begin
					timer_next = timer_reg - 32'h00000001;
				end
			end
			default: begin
				state_next = ST_IDLE;
				timer_next = 32'h00000000;
			end
		endcase
	end

	always @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_reg <= ST_IDLE;
			timer_reg <= 32'h00000000;
			done_reg <= 1'b0;
			converting_o <= 1'b0;
		end else begin
			state_reg <= state_next;
			timer_reg <= timer_next;
			done_reg <= done_next;
			converting_o <= (state_next == ST_CONV);
		end
	end

	// Limit comparison, one sign bit of headroom for hysteresis
	// 13-bit mode drops the three low bits
	wire [15:0] cmp_word = res16 ? adc_sample_i :
		{adc_sample_i[15:3], 3'h0};
	wire signed [16:0] cmp_s = {cmp_word[15], cmp_word};
	wire signed [16:0] crit_s = {critical_limit_i[15], critical_limit_i};
	wire signed [16:0] high_s = {high_limit_i[15], high_limit_i};
	wire signed [16:0] low_s = {low_limit_i[15], low_limit_i};
	wire signed [16:0] hyst_s = {6'h00, limit_hysteresis_i, 7'h00};
	wire crit_event = cmp_s > crit_s;
	wire high_event = cmp_s > high_s;
	wire low_event = cmp_s < low_s;
	wire crit_ended = cmp_s <= crit_s - hyst_s;
	wire limit_ended = (cmp_s <= high_s - hyst_s) &&
		(cmp_s >= low_s + hyst_s);

	always @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			measured_temperature_reg <= `TEMP_RESET;
		end else if (done_reg) begin
			if (res16)
				measured_temperature_reg <= adc_sample_i;
			else
				measured_temperature_reg <= {adc_sample_i[15:3],
					crit_event, high_event, low_event};
		end
	end

	alarm_output u_critical_alarm (
		.clk_sys_i(clk_sys_i),
		.reset_n_i(reset_n_i),
		.sample_valid_i(done_reg),
		.event_i(crit_event),
		.ended_i(crit_ended),
		.queue_code_i(sensor_settings_reg[`SET_QUEUE_MSB:`SET_QUEUE_LSB]),
		.comparator_i(sensor_settings_reg[`SET_CMP_MODE]),
		.active_high_i(sensor_settings_reg[`SET_CRIT_POL]),
		.clear_i(temp_read_reg),
		.alarm_o(critical_alarm_out_o)
	);

	alarm_output u_limit_alarm (
		.clk_sys_i(clk_sys_i),
		.reset_n_i(reset_n_i),
		.sample_valid_i(done_reg),
		.event_i(high_event | low_event),
		.ended_i(limit_ended),
		.queue_code_i(sensor_settings_reg[`SET_QUEUE_MSB:`SET_QUEUE_LSB]),
		.comparator_i(sensor_settings_reg[`SET_CMP_MODE]),
		.active_high_i(sensor_settings_reg[`SET_LIMIT_POL]),
		.clear_i(temp_read_reg),
		.alarm_o(limit_alarm_out_o)
	);
endmodule // temp_sensor_regs
`default_nettype wire

// >>> shared/temp_sensor_defs.vh
// Operation
// - Eight-bit settings register, readable and writable over the serial link.
// - Settings bits 1:0 choose consecutive faults needed: 00 one, 01 two, 11 four.
// - Settings bit 2 sets critical alarm level: 0 active low, 1 high.
// - Settings bit 3 sets limit alarm level: 0 active low, 1 high.
// - Settings bit 4: 0 interrupt behaviour, 1 comparator behaviour, both alarms.
// - Mode 00 restarts a conversion as soon as the previous one ends.
// - Mode 01 runs one conversion of 240 ms, then stops; written between mode 10 conversions it runs none.
// - Mode 10 converts once per second, each conversion 60 ms, until a settings write arrives between conversions.
// - Mode 11 stops conversions; serial register access keeps working.
// - Settings bit 7 picks 13-bit or 16-bit resolution, sign included.
// - Temperature held as 16-bit two's complement at address 0x02, read whole.
// - In 13-bit mode bits 2,1,0 are critical, high, low event flags.
// - In 16-bit mode bits 2:0 are the lowest temperature bits.
// - Read-only ID: maker code bits 7:3, revision bits 2:0.
// - Critical alarm when temperature exceeds critical limit, per queue, level, mode.
// - Limit alarm when below low or above high limit, per queue, level, mode.
// - Whole-degree hysteresis narrows limits when deciding an alarm has ended.
`ifndef TEMP_SENSOR_DEFS_VH
`define TEMP_SENSOR_DEFS_VH

`define ADDR_SENSOR_SETTINGS 3'h1
`define ADDR_MEASURED_TEMP 3'h2
`define ADDR_MAKER_REV 3'h3

`define SET_QUEUE_LSB 0
`define SET_QUEUE_MSB 1
`define SET_CRIT_POL 2
`define SET_LIMIT_POL 3
`define SET_CMP_MODE 4
`define SET_MODE_LSB 5
`define SET_MODE_MSB 6
`define SET_RES16 7
`define SET_RESET 8'h00

`define MODE_CONT 2'h0
`define MODE_ONESHOT 2'h1
`define MODE_SPS 2'h2
`define MODE_SHUTDOWN 2'h3

`define CMD_READ_BIT 6
`define CMD_ADDR_MSB 5
`define CMD_ADDR_LSB 3

`define TEMP_RESET 16'h0000
`define HYST_SHIFT 7

`define CLK_HZ 50000000
`define CYC_PER_MS (`CLK_HZ / 1000)
`define CONT_CONV_MS 240
`define ONESHOT_CONV_MS 240
`define SPS_CONV_MS 60
`define SPS_PERIOD_MS 1000

`endif

// >>> tb/spi_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
	input wire clk_i,
	input wire miso_i,
	output logic sclk_o,
	output logic cs_n_o,
	output logic mosi_o
);
	initial begin
		sclk_o = 1'b1;
		cs_n_o = 1'b1;
		mosi_o = 1'b0;
	end
	// Mode 3: drive on falling sclk, take miso late in the high half
	task automatic xfer(input logic [23:0] d, input int n,
		output logic [23:0] q);
		q = '0;
		@(negedge clk_i);
		cs_n_o = 1'b0;
		repeat (4) @(negedge clk_i);
		for (int i = n - 1; i >= 0; i--) begin
			sclk_o = 1'b0;
			mosi_o = d[i];
			repeat (4) @(negedge clk_i);
			sclk_o = 1'b1;
			repeat (4) @(negedge clk_i);
			q = {q[22:0], miso_i};
		end
		cs_n_o = 1'b1;
		// Released line shows the opposite of its last bit
		mosi_o = ~mosi_o;
		repeat (8) @(negedge clk_i);
	endtask
endmodule // spi_host_model
`default_nettype wire

// >>> tb/temp_sensor_regs_sva.sv
`timescale 1ns/1ps
`default_nettype none
module temp_sensor_regs_sva (
	input wire clk_sys_i,
	input wire reset_n_i,
	input wire sclk_i,
	input wire cs_n_i,
	input wire miso_o,
	input wire miso_oe_o,
	input wire critical_alarm_out_o,
	input wire limit_alarm_out_o,
	input wire converting_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!reset_n_i);
	property p_reset_idle;
		$rose(reset_n_i) |-> critical_alarm_out_o && limit_alarm_out_o;
	endproperty
	a_reset_idle: assert property (p_reset_idle)
		else $error("alarms not inactive after reset");
	property p_cont_start;
		$rose(reset_n_i) |-> ##[1:3] converting_o;
	endproperty
	a_cont_start: assert property (p_cont_start)
		else $error("no conversion after reset");
	property p_conv_min;
		$rose(converting_o) |-> converting_o[*8];
	endproperty
	a_conv_min: assert property (p_conv_min)
		else $error("conversion too short");
	property p_idle_out;
		(!miso_oe_o)[*2] |-> !miso_o;
	endproperty
	a_idle_out: assert property (p_idle_out)
		else $error("miso high while not driven");
	property p_deselect;
		cs_n_i[*8] |-> !miso_oe_o;
	endproperty
	a_deselect: assert property (p_deselect)
		else $error("miso driven while deselected");
	property p_select;
		(!cs_n_i)[*8] |-> miso_oe_o;
	endproperty
	a_select: assert property (p_select)
		else $error("miso not driven while selected");
	property p_miso_hold;
		(sclk_i && !cs_n_i)[*3] |-> $stable(miso_o);
	endproperty
	a_miso_hold: assert property (p_miso_hold)
		else $error("miso changed in high sclk half");
	property p_alarm_quiet;
		(cs_n_i && !converting_o)[*8] |->
			$stable(critical_alarm_out_o) && $stable(limit_alarm_out_o);
	endproperty
	a_alarm_quiet: assert property (p_alarm_quiet)
		else $error("alarm moved without a cause");
endmodule // temp_sensor_regs_sva
`default_nettype wire

// >>> tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
	localparam int P = 200;
	localparam [4:0] MAKER = 5'h0A; // arbitrary value
	localparam [2:0] REV = 3'h1; // arbitrary value
	logic clk_sys_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic sclk, cs_n, mosi, miso, miso_oe, crit_al, lim_al, conv;
	logic [15:0] adc = 16'h0300;
	logic [15:0] crit = 16'h0800;
	logic [15:0] high = 16'h0400;
	logic [15:0] low = 16'h0200;
	logic [3:0] hyst = 4'h1;
	logic [23:0] q;
	int mismatches = 0;
	int n_compared = 0;
	int cyc = 0;
	int n;
	temp_sensor_regs #(.MAKER_ID(MAKER), .REVISION_ID(REV),
		.CONT_CYCLES(P), .ONESHOT_CYCLES(240), .SPS_CONV_CYCLES(60),
		.SPS_PERIOD_CYCLES(1000)) uut (.clk_sys_i(clk_sys_i),
		.reset_n_i(reset_n_i), .sclk_i(sclk), .cs_n_i(cs_n), .mosi_i(mosi),
		.miso_o(miso), .miso_oe_o(miso_oe), .adc_sample_i(adc),
		.critical_limit_i(crit), .high_limit_i(high), .low_limit_i(low),
		.limit_hysteresis_i(hyst), .critical_alarm_out_o(crit_al),
		.limit_alarm_out_o(lim_al), .converting_o(conv));
	spi_host_model host (.clk_i(clk_sys_i), .miso_i(miso), .sclk_o(sclk),
		.cs_n_o(cs_n), .mosi_o(mosi));
	initial begin
		forever #10 clk_sys_i = ~clk_sys_i;
	end
	task report_and_stop;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	always @(posedge clk_sys_i) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			mismatches++;
			report_and_stop;
		end
	end
	task chk(input logic [23:0] got, input logic [23:0] exp);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task wr(input logic [7:0] v);
		host.xfer({8'h00, 8'h08, v}, 16, q);
	endtask
	task rd(input logic [2:0] a, input int b, input logic [15:0] exp);
		host.xfer({2'b01, a, 3'b000, 16'h0000} >> (24 - b), b, q);
		chk(b == 24 ? q[15:0] : q[7:0], exp);
	endtask
	task t_regs;
		rd(3'h1, 16, 16'h00);
		rd(3'h3, 16, {MAKER, REV});
		host.xfer({8'h00, 8'h18, 8'hFF}, 16, q);
		rd(3'h3, 16, {MAKER, REV});
		rd(3'h0, 16, 16'h00);
		chk({crit_al, lim_al}, 2'b11);
		wr(8'hA5);
		rd(3'h1, 16, 16'hA5);
		wr(8'h5A);
		rd(3'h1, 16, 16'h5A);
		host.xfer({8'h08, 4'hF}, 12, q);
		rd(3'h1, 16, 16'h5A);
		$display("regs done");
	endtask
	task t_temp;
		adc = 16'h0C87;
		wr(8'h00);
		repeat (2 * P) @(negedge clk_sys_i);
		rd(3'h2, 24, 16'h0C86);
		wr(8'h80);
		repeat (2 * P) @(negedge clk_sys_i);
		rd(3'h2, 24, 16'h0C87);
		adc = 16'h0105;
		wr(8'h00);
		repeat (2 * P) @(negedge clk_sys_i);
		rd(3'h2, 24, 16'h0101);
		$display("temp done");
	endtask
	task t_modes;
		int lo[4] = '{850, 200, 40, 0};
		int hi[4] = '{900, 240, 60, 0};
		for (int m = 0; m < 4; m++) begin
			wr({1'b0, m[1:0], 5'h00});
			n = 0;
			repeat (900) begin
				@(negedge clk_sys_i);
				n += conv;
			end
			chk(n >= lo[m] && n <= hi[m], 1'b1);
		end
		adc = 16'h0333;
		repeat (2 * P) @(negedge clk_sys_i);
		rd(3'h2, 24, 16'h0101);
		$display("modes done");
	endtask
	task t_alarm;
		for (int k = 3; k >= 0; k--) begin
			adc = 16'h0300;
			wr(8'h1C | k[7:0]);
			repeat (2 * P + 10) @(negedge clk_sys_i);
			chk({crit_al, lim_al}, 2'b00);
			adc = 16'h0C80;
			n = 0;
			while (crit_al !== 1'b1 && n < 2000) begin
				@(negedge clk_sys_i);
				n++;
			end
			chk(n > k * P && n <= (k + 1) * P, 1'b1);
			chk(lim_al, 1'b1);
		end
		adc = 16'h07C0;
		repeat (P + 10) @(negedge clk_sys_i);
		chk(crit_al, 1'b1);
		adc = 16'h0700;
		repeat (P + 10) @(negedge clk_sys_i);
		chk(crit_al, 1'b0);
		adc = 16'h0C80;
		wr(8'h0C);
		repeat (P + 10) @(negedge clk_sys_i);
		adc = 16'h0300;
		repeat (P + 10) @(negedge clk_sys_i);
		chk(crit_al, 1'b1);
		rd(3'h2, 24, 16'h0300);
		chk(crit_al, 1'b0);
		adc = 16'h0C80;
		wr(8'h00);
		repeat (P + 10) @(negedge clk_sys_i);
		chk({crit_al, lim_al}, 2'b00);
		$display("alarm done");
	endtask
	initial begin
		repeat (6) @(negedge clk_sys_i);
		reset_n_i = 1'b1;
		repeat (4) @(negedge clk_sys_i);
		t_regs;
		t_temp;
		t_modes;
		t_alarm;
		report_and_stop;
	end
endmodule // testbench
bind temp_sensor_regs temp_sensor_regs_sva chk_i (.clk_sys_i(clk_sys_i),
	.reset_n_i(reset_n_i), .sclk_i(sclk_i), .cs_n_i(cs_n_i),
	.miso_o(miso_o), .miso_oe_o(miso_oe_o),
	.critical_alarm_out_o(critical_alarm_out_o),
	.limit_alarm_out_o(limit_alarm_out_o), .converting_o(converting_o));
`default_nettype wire
